// ### bus_arb_pkg.sv
// shared constants and carrier types for the second-master bus arbiter
package bus_arb_pkg;

    // bus widths
    localparam int ADDR_W = 29;
    localparam int DATA_W = 32;
    localparam int LANES  = 4;
    localparam int LEN_W  = 2;

    // pin levels after reset: request off, host running, host drivers on
    localparam logic PREQ_N_RST = 1'b1;
    localparam logic WAIT_N_RST = 1'b1;
    localparam logic HOST_EN_RST = 1'b1;
    localparam logic OE_N_OFF   = 1'b1;

    // burst and lane layout
    localparam logic [LEN_W-1:0] QUAD_LEN  = 2'h3;
    localparam logic [LEN_W-1:0] LEN_ZERO  = 2'h0;
    localparam logic [3:0]       BE_WORD   = 4'hf;
    localparam logic [3:0]       BE_NONE   = 4'h0;
    localparam logic [1:0]       LANE_ZERO = 2'h0;
    localparam logic [3:0]       QUAD_ZERO = 4'h0;
    localparam logic [ADDR_W-1:0] WORD_STEP = 29'h0000004;

    // arbitration states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_ARB     = 7'h02,
        ST_STRETCH = 7'h04,
        ST_XFER    = 7'h08,
        ST_GAP     = 7'h10,
        ST_TURN    = 7'h20,
        ST_REL     = 7'h40
    } arb_state_type;

    // request from the second cpu side
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              keep_bus;
        logic [LEN_W-1:0]  len;
        logic [LANES-1:0]  be;
        logic [31:0]       addr;
    } cpu_req_type;

    // answer to the second cpu side
    typedef struct packed {
        logic              accept;
        logic              take;
        logic              beat;
        logic              last;
        logic [1:0]        idx;
        logic [DATA_W-1:0] rdata;
    } cpu_rsp_type;

    // shared bus outputs of the second master
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              rw_n;
        logic              bw_n;
        logic              addr_oe_n;
        logic              data_oe_n;
        logic [DATA_W-1:0] wdata;
    } bus_out_type;

endpackage

// ### lane_split.sv
// picks the next legal byte or word access out of a byte-enable mask
`timescale 1ns/1ps
module lane_split (
    input  wire logic [3:0] mask_i,
    output logic            word_o,
    output logic [1:0]      lane_o,
    output logic [3:0]      rest_o
);

    // full or empty mask is one word; anything else goes lowest byte first
    // so the addresses of the pieces only ever climb
    always_comb begin
        word_o = (mask_i == bus_arb_pkg::BE_WORD) ||
                 (mask_i == bus_arb_pkg::BE_NONE);
        lane_o = bus_arb_pkg::LANE_ZERO;
        rest_o = bus_arb_pkg::BE_NONE;
        if (!word_o) begin
            if (mask_i[0]) begin
                lane_o = 2'h0;
            end else if (mask_i[1]) begin
                lane_o = 2'h1;
            end else if (mask_i[2]) begin
                lane_o = 2'h2;
            end else begin
                lane_o = 2'h3;
            end
            rest_o = mask_i & ~(4'h1 << lane_o);
        end
    end

endmodule

// ### second_master_bus_arbiter.sv
// arbiter and protocol converter for a second master on the shared bus
//
// Behaviour
// R1: our bus request outranks the host's memory request.
// R2: second cpu requests are translated into shared-bus cycles.
// R3: unaligned or partial accesses split into legal byte or word accesses.
// R4: bursts climb strictly; a quad burst off its boundary restarts at base.
// R5: this block alone arbitrates and decides when to raise its request.
// R6: wait for safe point, stall host, then run access or burst.
// R7: decide while memory clock is high; outputs change on its falling edge.
// R8: one internal cycle separates host and second-master bursts.
// R9: request only once the host is about to run an internal cycle.
// R10: stretch that internal cycle, drop host bus enable, drive own address.
// R11: host bus enable low turns off host address, data, control drivers.
// R12: never request while the host's locked swap indicator is high.
// R13: after last transfer drop request, then restore enable, then unstall.
// R14: enable restored with host still stalled gives a turnaround cycle.
// R15: request gap of exactly one cycle keeps the bus for locked sequences.
// R16: longer gap gives the bus up; wait for internal cycle again.
// R17: only internal and sequential cycles; first access merges into both.
// R18: while we own the bus every action is timed by the memory clock.
// R19: bus request driven low means we want the bus next cycle.
// R20: stall line driven low freezes the host while we are active.
// R21: enable low tri-states host address, data, rw, bw and lock.
// R22: host drives lock high during a swap's read-write pair.
// R23: during reset: request off, stall released, host enable on.
`timescale 1ns/1ps
module second_master_bus_arbiter (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      mclk_i,
    input  wire logic                      host_mreq_n_i,
    input  wire logic                      host_lock_i,
    input  wire logic [31:0]               bus_data_i,
    input  wire bus_arb_pkg::cpu_req_type  cpu_req_i,
    input  wire logic [31:0]               cpu_wdata_i,
    output bus_arb_pkg::cpu_rsp_type       cpu_rsp_o,
    output bus_arb_pkg::bus_out_type       bus_o,
    output logic                           preq_n_o,
    output logic                           wait_n_o,
    output logic                           host_bus_output_enable_o
);

    // state and working copies
    bus_arb_pkg::arb_state_type    state_ff;
    bus_arb_pkg::arb_state_type    nxt_state;
    bus_arb_pkg::cpu_req_type      req_ff;
    logic [3:0]                    mask_ff;
    logic [bus_arb_pkg::LEN_W-1:0] beat_ff;
    logic [bus_arb_pkg::ADDR_W-1:0] addr_ff;
    logic                          mclk_ff;
    logic                          mreq_seen_ff;
    logic                          lock_seen_ff;
    logic                          pend_ff;
    logic                          pend_last_ff;
    logic                          pend_read_ff;
    logic [1:0]                    pend_idx_ff;
    logic                          preq_n_ff;
    logic                          wait_n_ff;
    logic                          host_en_ff;
    bus_arb_pkg::bus_out_type      bus_ff;
    bus_arb_pkg::cpu_rsp_type      rsp_ff;

    // decoded events
    logic       fall;
    logic       load;
    logic       launch;
    logic       last_beat;
    logic       safe_point;
    logic       keep_going;
    logic       split_word;
    logic [1:0] split_lane;
    logic [3:0] split_rest;
    logic [bus_arb_pkg::ADDR_W-1:0] beat_addr;
    logic [bus_arb_pkg::ADDR_W-1:0] start_addr;

    assign cpu_rsp_o                = rsp_ff;
    assign bus_o                    = bus_ff;
    assign preq_n_o                 = preq_n_ff;
    assign wait_n_o                 = wait_n_ff;
    assign host_bus_output_enable_o = host_en_ff;

    lane_split u_split (
        .mask_i (mask_ff),
        .word_o (split_word),
        .lane_o (split_lane),
        .rest_o (split_rest)
    );

    // no second stage: the pin is already in our clock domain
    // memory clock is sampled in our clock; its falling edge paces all pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mclk_ff <= 1'b0;
        end else begin
            mclk_ff <= mclk_i;
        end
    end

    assign fall = mclk_ff & ~mclk_i; // R7 R18

    // host cycle type and lock are judged only while the memory clock is high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mreq_seen_ff <= 1'b0;
            lock_seen_ff <= 1'b0;
        end else if (mclk_i) begin
            mreq_seen_ff <= host_mreq_n_i; // R7 R9
            lock_seen_ff <= host_lock_i;   // R12 R22
        end
    end

    // host about to run an internal cycle and not inside a swap
    assign safe_point = mreq_seen_ff & ~lock_seen_ff; // R9 R12

    // a held bus continues only when a new request is already waiting
    assign keep_going = req_ff.keep_bus & cpu_req_i.valid; // R15

    // beats are launched on the stretch edge and on each transfer edge
    assign launch = fall &&
                    (state_ff == bus_arb_pkg::ST_STRETCH ||
                     state_ff == bus_arb_pkg::ST_XFER); // R10 R17

    // a new request loads only when the block is free
    assign load = (state_ff == bus_arb_pkg::ST_IDLE && cpu_req_i.valid) ||
                  (state_ff == bus_arb_pkg::ST_GAP && fall &&
                   cpu_req_i.valid);

    // word beats count down; split bytes end when the mask empties
    assign last_beat = split_word ? (beat_ff == bus_arb_pkg::LEN_ZERO)
                                  : (split_rest == bus_arb_pkg::BE_NONE);

    // byte pieces use the lane address, words the aligned one
    assign beat_addr = split_word ? addr_ff
                                  : {addr_ff[bus_arb_pkg::ADDR_W-1:2],
                                     split_lane}; // R3

    // a quad burst that starts mid-line would wrap; restart it at the
    // quad base so addresses climb, and tag each beat with its index
    always_comb begin
        start_addr = {cpu_req_i.addr[bus_arb_pkg::ADDR_W-1:2], 2'h0};
        if (cpu_req_i.len == bus_arb_pkg::QUAD_LEN &&
            cpu_req_i.addr[3:2] != 2'h0) begin
            start_addr = {cpu_req_i.addr[bus_arb_pkg::ADDR_W-1:4],
                          bus_arb_pkg::QUAD_ZERO}; // R4
        end
    end

    // arbitration sequence
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bus_arb_pkg::ST_IDLE: begin
                if (cpu_req_i.valid) begin
                    nxt_state = bus_arb_pkg::ST_ARB; // R5
                end
            end

            bus_arb_pkg::ST_ARB: begin
                if (fall && safe_point) begin
                    nxt_state = bus_arb_pkg::ST_STRETCH; // R6 R9 R12
                end
            end

            bus_arb_pkg::ST_STRETCH,
            bus_arb_pkg::ST_XFER: begin
                if (launch && last_beat) begin
                    nxt_state = keep_going ? bus_arb_pkg::ST_GAP
                                           : bus_arb_pkg::ST_TURN; // R13
                end else if (fall) begin
                    nxt_state = bus_arb_pkg::ST_XFER;
                end
            end

            bus_arb_pkg::ST_GAP: begin
                if (fall) begin
                    nxt_state = cpu_req_i.valid ? bus_arb_pkg::ST_XFER
                                                : bus_arb_pkg::ST_TURN; // R16
                end
            end

            bus_arb_pkg::ST_TURN: begin
                if (fall) begin
                    nxt_state = bus_arb_pkg::ST_REL; // R14
                end
            end

            bus_arb_pkg::ST_REL: begin
                if (fall) begin
                    nxt_state = bus_arb_pkg::ST_IDLE; // R8 R16
                end
            end

            default: begin
                nxt_state = bus_arb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= bus_arb_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // request copy and beat bookkeeping
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            req_ff  <= '0;
            mask_ff <= bus_arb_pkg::BE_NONE;
            beat_ff <= bus_arb_pkg::LEN_ZERO;
            addr_ff <= '0;
        end else if (load) begin
            req_ff  <= cpu_req_i; // R2
            beat_ff <= cpu_req_i.len;
            addr_ff <= start_addr;
            // partial masks only make sense on a single access
            mask_ff <= (cpu_req_i.len == bus_arb_pkg::LEN_ZERO)
                       ? cpu_req_i.be : bus_arb_pkg::BE_WORD; // R3
        end else if (launch) begin
            if (split_word) begin
                beat_ff <= beat_ff - 2'h1;
                addr_ff <= addr_ff + bus_arb_pkg::WORD_STEP; // R4
            end else begin
                mask_ff <= split_rest; // R3
            end
        end
    end

    // request, stall and host enable pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            preq_n_ff <= bus_arb_pkg::PREQ_N_RST; // R23
            wait_n_ff <= bus_arb_pkg::WAIT_N_RST; // R23
            host_en_ff <= bus_arb_pkg::HOST_EN_RST; // R23
        end else if (fall) begin
            case (state_ff)
                bus_arb_pkg::ST_ARB: begin
                    if (safe_point) begin
                        // our request wins over the host's next one
                        preq_n_ff <= 1'b0; // R1 R19
                        wait_n_ff <= 1'b0; // R6 R20
                    end
                end
                bus_arb_pkg::ST_STRETCH: begin
                    host_en_ff <= 1'b0; // R10 R11 R21
                    if (last_beat) begin
                        preq_n_ff <= 1'b1; // R13
                    end
                end
                bus_arb_pkg::ST_XFER: begin
                    if (last_beat) begin
                        preq_n_ff <= 1'b1; // R13
                    end
                end
                bus_arb_pkg::ST_GAP: begin
                    // one-cycle gap keeps ownership for locked sequences
                    if (cpu_req_i.valid) begin
                        preq_n_ff <= 1'b0; // R15
                    end
                end
                bus_arb_pkg::ST_TURN: begin
                    // host drivers back on; host clock still held
                    host_en_ff <= 1'b1; // R13 R14
                end
                bus_arb_pkg::ST_REL: begin
                    // host resumes one cycle after its drivers return
                    wait_n_ff <= 1'b1; // R13
                end
                default: begin
                    preq_n_ff <= preq_n_ff;
                end
            endcase
        end
    end

    // shared bus drivers; only on while the host enable is held low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_ff.addr      <= '0;
            bus_ff.rw_n      <= 1'b0;
            bus_ff.bw_n      <= 1'b1;
            bus_ff.addr_oe_n <= bus_arb_pkg::OE_N_OFF;
            bus_ff.data_oe_n <= bus_arb_pkg::OE_N_OFF;
            bus_ff.wdata     <= '0;
        end else if (launch) begin
            bus_ff.addr      <= beat_addr; // R10
            bus_ff.rw_n      <= req_ff.write;
            bus_ff.bw_n      <= split_word; // R3
            bus_ff.addr_oe_n <= 1'b0;
            bus_ff.data_oe_n <= ~req_ff.write;
            // bytes go out on every lane so any lane decode sees them
            bus_ff.wdata     <= split_word
                                ? cpu_wdata_i
                                : {4{cpu_wdata_i[{split_lane, 3'h0} +: 8]}};
        end else if (fall) begin
            bus_ff.data_oe_n <= bus_arb_pkg::OE_N_OFF;
            if (state_ff == bus_arb_pkg::ST_TURN) begin
                // let go on the same fall that turns the host drivers back on
                bus_ff.addr_oe_n <= bus_arb_pkg::OE_N_OFF; // R14
            end
        end
    end

    // beat in flight; its data is on the bus at the next falling edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend_ff      <= 1'b0;
            pend_last_ff <= 1'b0;
            pend_read_ff <= 1'b0;
            pend_idx_ff  <= 2'h0;
        end else if (fall) begin
            pend_ff      <= launch;
            pend_last_ff <= launch & last_beat;
            pend_read_ff <= ~req_ff.write;
            pend_idx_ff  <= addr_ff[3:2]; // R4
        end
    end

    // answers to the second cpu: pulses only, data held until next beat
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.accept <= load;
            rsp_ff.take   <= launch & req_ff.write;
            rsp_ff.beat   <= fall & pend_ff;
            if (fall && pend_ff) begin
                rsp_ff.last <= pend_last_ff;
                rsp_ff.idx  <= pend_idx_ff;
                if (pend_read_ff) begin
                    rsp_ff.rdata <= bus_data_i; // R2
                end
            end
        end
    end

endmodule

// ### arb_sva.sv
// assertion checker for the second-master arbiter pins
`timescale 1ns/1ps
module arb_sva (
    input wire logic                     clk_i,
    input wire logic                     rst_n_i,
    input wire logic                     mclk_i,
    input wire logic                     host_mreq_n_i,
    input wire logic                     host_lock_i,
    input wire bus_arb_pkg::cpu_rsp_type cpu_rsp_o,
    input wire bus_arb_pkg::bus_out_type bus_o,
    input wire logic                     preq_n_o,
    input wire logic                     wait_n_o,
    input wire logic                     host_bus_output_enable_o
);
    logic mclk_q_ff;
    logic fall_ff;
    logic fall;

    // history cleared by reset, so a fall needs a high sample first
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mclk_q_ff <= 1'b0;
            fall_ff   <= 1'b0;
        end else begin
            mclk_q_ff <= mclk_i;
            fall_ff   <= fall;
        end
    end
    assign fall = mclk_q_ff & ~mclk_i;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // bus taken from a running host
    sequence s_grab;
        $fell(preq_n_o) && $past(wait_n_o);
    endsequence
    sequence s_en_back;
        $rose(host_bus_output_enable_o);
    endsequence

    a_reset_levels: assert property ($rose(rst_n_i) |-> preq_n_o
        && wait_n_o && host_bus_output_enable_o)
        else $error("pins not at reset levels");
    a_pins_at_fall: assert property (!fall |=> $stable(preq_n_o)
        && $stable(wait_n_o) && $stable(host_bus_output_enable_o))
        else $error("pin moved away from a memory clock fall");
    a_req_needs_idle: assert property (s_grab |->
        $past(host_mreq_n_i, 2) && !$past(host_lock_i, 2))
        else $error("request raised without a safe host cycle");
    a_stall_with_req: assert property (s_grab |-> $fell(wait_n_o))
        else $error("request raised without stalling the host");
    a_release_order: assert property (s_en_back |->
        $past(preq_n_o, 8) && !wait_n_o ##8 $rose(wait_n_o))
        else $error("release order broken");
    a_host_off_drive: assert property ((!bus_o.addr_oe_n
        || !bus_o.data_oe_n) |-> !host_bus_output_enable_o)
        else $error("own drivers on while host drivers on");
    a_en_in_stall: assert property (!host_bus_output_enable_o
        |-> !wait_n_o)
        else $error("host drivers off while host runs");
    a_beat_at_fall: assert property (cpu_rsp_o.beat |-> fall_ff
        && !wait_n_o)
        else $error("beat not paced by memory clock");
    a_word_aligned: assert property (!bus_o.addr_oe_n && bus_o.bw_n
        |-> bus_o.addr[1:0] == 2'h0)
        else $error("unaligned word access on the bus");
endmodule

bind second_master_bus_arbiter arb_sva u_arb_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mclk_i(mclk_i),
    .host_mreq_n_i(host_mreq_n_i), .host_lock_i(host_lock_i),
    .cpu_rsp_o(cpu_rsp_o), .bus_o(bus_o), .preq_n_o(preq_n_o),
    .wait_n_o(wait_n_o),
    .host_bus_output_enable_o(host_bus_output_enable_o));

// ### host_model.sv
// host processor and memory controller stand-in on the shared bus
`timescale 1ns/1ps
module host_model (
    input  wire logic                     clk_i,
    input  wire logic                     busy_i,
    input  wire logic                     lock_i,
    input  wire logic                     host_en_i,
    input  wire bus_arb_pkg::bus_out_type bus_i,
    output logic                          mclk_o,
    output logic                          host_mreq_n_o,
    output logic                          host_lock_o,
    output logic [31:0]                   bus_data_o,
    output logic [28:0]                   wr_addr_o,
    output logic [31:0]                   wr_data_o,
    output logic                          wr_bw_n_o
);
    logic [2:0]  cnt_ff = 3'h0;
    logic        mclk_q_ff = 1'b0;
    logic [31:0] last_ff = 32'h0;
    logic        rd;

    initial mclk_o = 1'b1;
    initial host_mreq_n_o = 1'b1;
    initial host_lock_o = 1'b0;
    // memory clock runs free: four system clocks high, four low
    always @(posedge clk_i) begin
        cnt_ff <= cnt_ff + 3'h1;
        mclk_o <= (cnt_ff + 3'h1) < 3'h4;
        mclk_q_ff <= mclk_o;
        last_ff <= bus_data_o;
        if (cnt_ff == 3'h7) begin
            host_mreq_n_o <= ~busy_i;
            host_lock_o <= lock_i;
        end
        // memory takes a write at the fall that ends the beat
        if (mclk_q_ff && !mclk_o && rd && bus_i.rw_n && !bus_i.data_oe_n) begin
            wr_addr_o <= bus_i.addr;
            wr_data_o <= bus_i.wdata;
            wr_bw_n_o <= bus_i.bw_n;
        end
    end

    // host drivers stay off while enable is low; idle bus keeps toggling
    assign rd = !host_en_i && !bus_i.addr_oe_n;
    assign bus_data_o = (rd && !bus_i.rw_n) ?
        ({3'h0, bus_i.addr[28:2], 2'h0} ^ 32'h5a5a0000) : ~last_ff;
endmodule

// ### tb_top.sv
// self-checking bench for the second-master bus arbiter
`timescale 1ns/1ps
module tb_top;
    logic                     clk_i, rst_n_i, busy, lock, mclk, mreq_n;
    logic                     hlock, host_en, preq_n, wait_n, wr_bw_n;
    logic [31:0]              bus_data, cpu_wdata_i, wr_data;
    logic [28:0]              wr_addr;
    bus_arb_pkg::cpu_req_type cpu_req_i;
    bus_arb_pkg::cpu_rsp_type cpu_rsp_o;
    bus_arb_pkg::bus_out_type bus_o;
    int                       bad_count, checks_done;
    int                       en_rise = 0;
    int                       preq_rise = 0;

    second_master_bus_arbiter uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .mclk_i(mclk),
        .host_mreq_n_i(mreq_n), .host_lock_i(hlock), .bus_data_i(bus_data),
        .cpu_req_i(cpu_req_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_rsp_o(cpu_rsp_o), .bus_o(bus_o), .preq_n_o(preq_n),
        .wait_n_o(wait_n), .host_bus_output_enable_o(host_en));
    host_model u_host (
        .clk_i(clk_i), .busy_i(busy), .lock_i(lock), .host_en_i(host_en),
        .bus_i(bus_o), .mclk_o(mclk), .host_mreq_n_o(mreq_n),
        .host_lock_o(hlock), .bus_data_o(bus_data), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .wr_bw_n_o(wr_bw_n));

    // handover counters, read only long after the edges settle
    always @(posedge host_en) en_rise++;
    always @(posedge preq_n) preq_rise++;

    function automatic logic [31:0] mem_of(input logic [31:0] a);
        return {3'h0, a[28:2], 2'h0} ^ 32'h5a5a0000;
    endfunction
    function automatic logic [31:0] wd(input int i);
        return 32'hc0de0000 + 32'(i);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk("reset pins", 32'hf, {28'h0, preq_n, wait_n, host_en,
            bus_o.addr_oe_n});
    endtask

    // request held until accepted, as the handshake demands
    task automatic issue(input logic [31:0] a, input logic [1:0] ln,
                         input logic [3:0] b, input logic w, k);
        int t;
        cpu_req_i <= '{valid:1'b1, write:w, keep_bus:k, len:ln, be:b, addr:a};
        for (t = 0; t < 400; t++) begin
            @(posedge clk_i);
            if (cpu_rsp_o.accept === 1'b1) break;
        end
        cpu_req_i.valid <= 1'b0;
        chk("accept", 32'h1, {31'h0, cpu_rsp_o.accept});
    endtask

    task automatic beats(input logic [31:0] a, input logic [1:0] ln,
                         input logic [3:0] b, input logic w, input int nb);
        int t, n, tk, l;
        logic [31:0] ea, wv;
        logic [3:0] rest;
        n = 0;
        tk = 1;
        rest = b;
        wv = wd(0);
        ea = (ln == 2'h3) ? {a[31:4], 4'h0} : {a[31:2], 2'h0};
        for (t = 0; t < 600 && n < nb; t++) begin
            @(posedge clk_i);
            if (cpu_rsp_o.take === 1'b1 && ln != 2'h0) begin
                cpu_wdata_i <= wd(tk);
                tk++;
            end
            if (cpu_rsp_o.beat === 1'b1) begin
                chk("last", {31'h0, n == nb - 1}, {31'h0, cpu_rsp_o.last});
                if (!w) begin
                    chk("index", {30'h0, ea[3:2]}, {30'h0, cpu_rsp_o.idx});
                    chk("read data", mem_of(ea), cpu_rsp_o.rdata);
                end else if (ln != 2'h0 || b == 4'hf) begin
                    chk("write addr", ea, {3'h0, wr_addr});
                    chk("write data", wd(n), wr_data);
                    chk("write size", 32'h1, {31'h0, wr_bw_n});
                end else begin
                    l = 0;
                    while (l < 3 && !rest[l]) l++;
                    rest[l] = 1'b0;
                    chk("byte addr", {a[31:2], 2'(l)}, {3'h0, wr_addr});
                    chk("byte data", {24'h0, wv[l*8 +: 8]},
                        {24'h0, wr_data[l*8 +: 8]});
                    chk("byte size", 32'h0, {31'h0, wr_bw_n});
                end
                ea = ea + 32'h4;
                n++;
            end
        end
        chk("beat count", 32'(nb), 32'(n));
    endtask

    task automatic xfer(input logic [31:0] a, input logic [1:0] ln,
                        input logic [3:0] b, input logic w, input int nb);
        issue(a, ln, b, w, 1'b0);
        beats(a, ln, b, w, nb);
    endtask

    task automatic t_words;
        cpu_wdata_i <= wd(0);
        xfer(32'h1230, 2'h0, 4'hf, 1'b0, 1);
        xfer(32'h2008, 2'h0, 4'hf, 1'b1, 1);
        xfer(32'h4028, 2'h3, 4'hf, 1'b0, 4);
        xfer(32'h5008, 2'h1, 4'hf, 1'b1, 2);
        $display("words done");
    endtask

    task automatic t_bytes;
        cpu_wdata_i <= wd(0);
        xfer(32'h6000, 2'h0, 4'ha, 1'b1, 2);
        xfer(32'h6104, 2'h0, 4'h7, 1'b1, 3);
        $display("bytes done");
    endtask

    // a busy or locked host must hold off the request
    task automatic t_hold;
        for (int m = 0; m < 2; m++) begin
            busy <= (m == 0);
            lock <= (m == 1);
            issue(32'h3000, 2'h0, 4'hf, 1'b0, 1'b0);
            repeat (64) @(posedge clk_i);
            chk("held request", 32'h1, {31'h0, preq_n});
            busy <= 1'b0;
            lock <= 1'b0;
            beats(32'h3000, 2'h0, 4'hf, 1'b0, 1);
        end
        $display("hold done");
    endtask

    task automatic t_locked;
        int e0, p0;
        e0 = en_rise;
        p0 = preq_rise;
        issue(32'h7000, 2'h0, 4'hf, 1'b0, 1'b1);
        @(posedge clk_i);
        xfer(32'h7010, 2'h0, 4'hf, 1'b0, 1);
        repeat (24) @(posedge clk_i);
        chk("enable rises", 32'h1, 32'(en_rise - e0));
        chk("request rises", 32'h2, 32'(preq_rise - p0));
        issue(32'h7020, 2'h0, 4'hf, 1'b0, 1'b1);
        beats(32'h7020, 2'h0, 4'hf, 1'b0, 1);
        repeat (24) @(posedge clk_i);
        chk("released", 32'h3, {30'h0, wait_n, host_en});
        $display("locked done");
    endtask

    task automatic t_abort;
        issue(32'h8000, 2'h3, 4'hf, 1'b0, 1'b0);
        for (int t = 0; t < 200 && host_en !== 1'b0; t++) @(posedge clk_i);
        chk("bus taken", 32'h0, {31'h0, host_en});
        do_reset;
        $display("abort done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // run well past the expected few thousand ns before giving up
    initial begin
        #80000;
        bad_count++;
        stop_test;
    end

    initial begin
        rst_n_i = 1'b0;
        busy = 1'b0;
        lock = 1'b0;
        cpu_req_i = '0;
        cpu_wdata_i = 32'h0;
        bad_count = 0;
        checks_done = 0;
        do_reset;
        t_words;
        t_bytes;
        t_hold;
        t_locked;
        t_abort;
        t_words;
        stop_test;
    end
endmodule
